/* File: logic/himsel_pkg.sv */
// package for the host interface mode decoder: strap codes, mode enum, lane layout
// assumes the straps and host pins are sampled on one 20 MHz reference clock
package himsel_pkg;

  localparam int HIMSEL_STRAP_W  = 4;
  localparam int HIMSEL_LANES_W  = 18;
  localparam int HIMSEL_BYTE_W   = 8;
  localparam int HIMSEL_PIX_W    = 18;

  // strap codes
  localparam logic [3:0] HIMSEL_C_P8_A    = 4'h0;
  localparam logic [3:0] HIMSEL_C_P16_A   = 4'h1;
  localparam logic [3:0] HIMSEL_C_P9_A    = 4'h2;
  localparam logic [3:0] HIMSEL_C_P18_A   = 4'h3;
  localparam logic [3:0] HIMSEL_C_S3_A    = 4'h5;
  localparam logic [3:0] HIMSEL_C_S4_A    = 4'h6;
  localparam logic [3:0] HIMSEL_C_P16_B   = 4'h8;
  localparam logic [3:0] HIMSEL_C_P8_B    = 4'h9;
  localparam logic [3:0] HIMSEL_C_P18_B   = 4'hA;
  localparam logic [3:0] HIMSEL_C_P9_B    = 4'hB;
  localparam logic [3:0] HIMSEL_C_S3_B    = 4'hD;
  localparam logic [3:0] HIMSEL_C_S4_B    = 4'hE;

  // lane field positions
  localparam int HIMSEL_LO_BYTE_LSB = 0;
  localparam int HIMSEL_MID_BYTE_LSB = 1;
  localparam int HIMSEL_HI_BYTE_LSB = 10;
  localparam int HIMSEL_HI9_LSB     = 9;

  // serial word lengths
  localparam logic [3:0] HIMSEL_SER3_BITS = 4'h9;
  localparam logic [3:0] HIMSEL_SER4_BITS = 4'h8;

  typedef enum logic [3:0] {
    HIMSEL_M_P8_A,
    HIMSEL_M_P16_A,
    HIMSEL_M_P9_A,
    HIMSEL_M_P18_A,
    HIMSEL_M_S3_A,
    HIMSEL_M_S4_A,
    HIMSEL_M_P16_B,
    HIMSEL_M_P8_B,
    HIMSEL_M_P18_B,
    HIMSEL_M_P9_B,
    HIMSEL_M_S3_B,
    HIMSEL_M_S4_B,
    HIMSEL_M_RSVD
  } himsel_mode_t;

endpackage

/* File: logic/himsel_top.sv */
// host interface mode decoder: straps to mode, parallel lane steering per mode
// assumes all host pins are asynchronous and are double-synchronised here
// Overview of operation
// - 0000: family one, all bytes lanes[7:0]
// - 0001: commands lanes[7:0], pixels lanes[15:0]
// - 0010: commands lanes[7:0], pixels lanes[8:0]
// - 0011: commands lanes[7:0], pixels lanes[17:0]
// - 0101: 3-line 9-bit serial, shared line
// - 0110: 4-line 8-bit serial, shared line
// - 1000: commands lanes[8:1], pixels lanes[17:10]+[8:1]
// - 1001: all bytes on lanes[17:10]
// - 1010: commands lanes[8:1], pixels lanes[17:0]
// - 1011: commands lanes[17:10], pixels lanes[17:9]
// - 1101: 3-line 9-bit serial, split lines
// - 1110: 4-line 8-bit serial, split lines
// - data_cmd_select high data, low command
// - strobes ignored while chip select high
`timescale 1ns/1ps
module himsel_top
  import himsel_pkg::*;
(
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_iface_sel_bit3,
  input  wire logic                          i_iface_sel_bit2,
  input  wire logic                          i_iface_sel_bit1,
  input  wire logic                          i_iface_sel_bit0,
  input  wire logic [himsel_pkg::HIMSEL_LANES_W-1:0] i_host_data_lanes,
  input  wire logic                          i_chip_select_n,
  input  wire logic                          i_data_cmd_select,
  input  wire logic                          i_write_n,
  output logic [3:0]                         o_mode,
  output logic                               o_mode_valid,
  output logic                               o_serial_mode,
  output logic                               o_serial_split,
  output logic [3:0]                         o_serial_word_bits,
  output logic                               o_cmd_valid,
  output logic [himsel_pkg::HIMSEL_BYTE_W-1:0] o_cmd_byte,
  output logic                               o_param_valid,
  output logic [himsel_pkg::HIMSEL_BYTE_W-1:0] o_param_byte,
  output logic                               o_pixel_valid,
  output logic [himsel_pkg::HIMSEL_PIX_W-1:0]  o_pixel_word,
  output logic                               o_rgb_allowed
);
  import himsel_pkg::*;

  // two-stage synchronisers; the first stage feeds only the second
  logic [HIMSEL_STRAP_W-1:0] strap_s1_r, strap_s2_r;
  logic [HIMSEL_LANES_W-1:0] lanes_s1_r, lanes_s2_r;
  logic [2:0]                ctl_s1_r, ctl_s2_r;
  logic                      wr_n_d_r;
  logic [1:0]                strap_fill_r;
  himsel_mode_t              mode_r, mode_nxt;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      strap_s1_r <= '0;
      strap_s2_r <= '0;
      lanes_s1_r <= '0;
      lanes_s2_r <= '0;
      ctl_s1_r   <= 3'h7;
      ctl_s2_r   <= 3'h7;
    end
    else
    begin
      strap_s1_r <= {i_iface_sel_bit3, i_iface_sel_bit2, i_iface_sel_bit1, i_iface_sel_bit0};
      strap_s2_r <= strap_s1_r;
      lanes_s1_r <= i_host_data_lanes;
      lanes_s2_r <= lanes_s1_r;
      ctl_s1_r   <= {i_chip_select_n, i_data_cmd_select, i_write_n};
      ctl_s2_r   <= ctl_s1_r;
    end
  end

  wire cs_n_s = ctl_s2_r[2];
  wire dc_s   = ctl_s2_r[1];
  wire wr_n_s = ctl_s2_r[0];

  function automatic himsel_mode_t decode_strap(input logic [3:0] code);
    case (code)
      HIMSEL_C_P8_A:  decode_strap = HIMSEL_M_P8_A;
      HIMSEL_C_P16_A: decode_strap = HIMSEL_M_P16_A;
      HIMSEL_C_P9_A:  decode_strap = HIMSEL_M_P9_A;
      HIMSEL_C_P18_A: decode_strap = HIMSEL_M_P18_A;
      HIMSEL_C_S3_A:  decode_strap = HIMSEL_M_S3_A;
      HIMSEL_C_S4_A:  decode_strap = HIMSEL_M_S4_A;
      HIMSEL_C_P16_B: decode_strap = HIMSEL_M_P16_B;
      HIMSEL_C_P8_B:  decode_strap = HIMSEL_M_P8_B;
      HIMSEL_C_P18_B: decode_strap = HIMSEL_M_P18_B;
      HIMSEL_C_P9_B:  decode_strap = HIMSEL_M_P9_B;
      HIMSEL_C_S3_B:  decode_strap = HIMSEL_M_S3_B;
      HIMSEL_C_S4_B:  decode_strap = HIMSEL_M_S4_B;
      default:        decode_strap = HIMSEL_M_RSVD;
    endcase
  endfunction

  // the strap stages restart at zero, which is a listed code; hold the mode
  // reserved until both stages carry real samples, so no false mode follows reset
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      strap_fill_r <= '0;
    else
      strap_fill_r <= {strap_fill_r[0], 1'h1};
  end

  // mode tracks the synchronised straps; straps are static so no glitch filter
  always_comb
  begin
    mode_nxt = strap_fill_r[1] ? decode_strap(strap_s2_r) : HIMSEL_M_RSVD;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      mode_r <= HIMSEL_M_RSVD;
    else
      mode_r <= mode_nxt;
  end

  wire is_serial = (mode_r == HIMSEL_M_S3_A) || (mode_r == HIMSEL_M_S4_A) ||
                   (mode_r == HIMSEL_M_S3_B) || (mode_r == HIMSEL_M_S4_B);
  wire is_par    = (mode_r != HIMSEL_M_RSVD) && !is_serial;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_mode             <= '0;
      o_mode_valid       <= 1'b0;
      o_serial_mode      <= 1'b0;
      o_serial_split     <= 1'b0;
      o_serial_word_bits <= '0;
      o_rgb_allowed      <= 1'b0;
    end
    else
    begin
      o_mode         <= 4'(mode_r);
      o_mode_valid   <= (mode_r != HIMSEL_M_RSVD);
      o_serial_mode  <= is_serial;
      o_serial_split <= (mode_r == HIMSEL_M_S3_B) || (mode_r == HIMSEL_M_S4_B);
      o_rgb_allowed  <= is_serial;
      if ((mode_r == HIMSEL_M_S3_A) || (mode_r == HIMSEL_M_S3_B))
        o_serial_word_bits <= HIMSEL_SER3_BITS;
      else if (is_serial)
        o_serial_word_bits <= HIMSEL_SER4_BITS;
      else
        o_serial_word_bits <= '0;
    end
  end

  // write strobe rising edge taken only with chip select low
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      wr_n_d_r <= 1'b1;
    else
      wr_n_d_r <= wr_n_s;
  end

  wire wr_take = is_par && !cs_n_s && wr_n_s && !wr_n_d_r;

  function automatic logic [HIMSEL_BYTE_W-1:0] cmd_lanes(input himsel_mode_t m,
                                                         input logic [HIMSEL_LANES_W-1:0] d);
    case (m)
      HIMSEL_M_P16_B, HIMSEL_M_P18_B:
        cmd_lanes = d[HIMSEL_MID_BYTE_LSB +: HIMSEL_BYTE_W];
      HIMSEL_M_P8_B, HIMSEL_M_P9_B:
        cmd_lanes = d[HIMSEL_HI_BYTE_LSB +: HIMSEL_BYTE_W];
      default:
        cmd_lanes = d[HIMSEL_LO_BYTE_LSB +: HIMSEL_BYTE_W];
    endcase
  endfunction

  // pixel words are right-aligned; the 16-bit family-two word packs two byte lanes
  function automatic logic [HIMSEL_PIX_W-1:0] pix_lanes(input himsel_mode_t m,
                                                        input logic [HIMSEL_LANES_W-1:0] d);
    case (m)
      HIMSEL_M_P8_A:  pix_lanes = {10'h000, d[7:0]};
      HIMSEL_M_P16_A: pix_lanes = {2'h0, d[15:0]};
      HIMSEL_M_P9_A:  pix_lanes = {9'h000, d[8:0]};
      HIMSEL_M_P18_A: pix_lanes = d;
      HIMSEL_M_P16_B: pix_lanes = {2'h0, d[17:10], d[8:1]};
      HIMSEL_M_P8_B:  pix_lanes = {10'h000, d[17:10]};
      HIMSEL_M_P18_B: pix_lanes = d;
      HIMSEL_M_P9_B:  pix_lanes = {9'h000, d[17:HIMSEL_HI9_LSB]};
      default:        pix_lanes = '0;
    endcase
  endfunction

  // the command set is out of scope, so every data write is offered to the
  // core as both parameter and pixel; the core picks by command context

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_cmd_valid   <= 1'b0;
      o_cmd_byte    <= '0;
      o_param_valid <= 1'b0;
      o_param_byte  <= '0;
      o_pixel_valid <= 1'b0;
      o_pixel_word  <= '0;
    end
    else
    begin
      o_cmd_valid   <= wr_take && !dc_s;
      o_param_valid <= wr_take && dc_s;
      o_pixel_valid <= wr_take && dc_s;
      if (wr_take && !dc_s)
        o_cmd_byte <= cmd_lanes(mode_r, lanes_s2_r);
      if (wr_take && dc_s)
      begin
        o_param_byte <= cmd_lanes(mode_r, lanes_s2_r);
        o_pixel_word <= pix_lanes(mode_r, lanes_s2_r);
      end
    end
  end

endmodule

/* File: verif/himsel_asserts.sv */
// checker for the mode decoder: mode outputs agree, write pulses obey chip select
// assumes binding onto himsel_top, one clock domain
`timescale 1ns/1ps
module himsel_asserts
(
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic       i_chip_select_n,
  input wire logic [3:0] o_mode,
  input wire logic       o_mode_valid,
  input wire logic       o_serial_mode,
  input wire logic       o_serial_split,
  input wire logic [3:0] o_serial_word_bits,
  input wire logic       o_cmd_valid,
  input wire logic       o_param_valid,
  input wire logic       o_pixel_valid,
  input wire logic       o_rgb_allowed
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // six idle cycles cover the two sync stages and the edge detector
  sequence cs_idle;
    i_chip_select_n [*6];
  endsequence
  sequence any_write;
    o_cmd_valid || o_param_valid;
  endsequence
  AST_RSVD: assert property (o_mode == 4'hC |-> !o_mode_valid && !o_serial_mode)
    else $error("reserved mode flagged valid");
  AST_SER3: assert property (o_mode inside {4'h4, 4'hA} |-> o_serial_word_bits == 4'h9)
    else $error("3-line word length wrong");
  AST_SER4: assert property (o_mode inside {4'h5, 4'hB} |-> o_serial_word_bits == 4'h8)
    else $error("4-line word length wrong");
  AST_SPLIT: assert property (o_mode_valid |-> o_serial_split == (o_mode inside {4'hA, 4'hB}))
    else $error("split line flag wrong");
  AST_RGB: assert property (o_rgb_allowed |-> o_serial_mode)
    else $error("rgb allowed outside serial");
  AST_PAIR: assert property (o_param_valid |-> o_pixel_valid && !o_cmd_valid)
    else $error("data write not paired");
  AST_CS: assert property (cs_idle |=> !any_write)
    else $error("write taken with chip select high");
  AST_NOPAR: assert property (o_serial_mode || !o_mode_valid |-> !any_write)
    else $error("parallel write taken in wrong mode");
  AST_PULSE: assert property ($rose(o_cmd_valid) |=> !o_cmd_valid)
    else $error("command pulse too long");
endmodule

/* File: verif/himsel_host.sv */
// host model: drives one parallel write per call, releases the lanes afterwards
// assumes the caller holds the falling edge clock phase
`timescale 1ns/1ps
module himsel_host
(
  input  wire logic        i_clk,
  output logic [17:0]      o_lanes,
  output logic             o_cs_n,
  output logic             o_dc,
  output logic             o_wr_n
);
  initial
  begin
    o_lanes = 18'h00000;
    o_cs_n  = 1'b1;
    o_dc    = 1'b0;
    o_wr_n  = 1'b1;
  end
  task automatic write(input logic cs_n, input logic dc, input logic [17:0] d);
    @(negedge i_clk);
    o_cs_n  = cs_n;
    o_dc    = dc;
    o_lanes = d;
    o_wr_n  = 1'b0;
    repeat (3) @(negedge i_clk);
    o_wr_n = 1'b1;
    repeat (3) @(negedge i_clk);
    o_cs_n = 1'b1;
    // released lanes must not keep the old value
    o_lanes = ~d;
    o_dc    = ~dc;
  endtask
endmodule

/* File: verif/himsel_top_tb.sv */
// bench for himsel_top: strap decode table and lane steering per code
// assumes the host model is the only driver of the bus pins
`timescale 1ns/1ps
module himsel_top_tb;
  import himsel_pkg::*;
  logic clk = 1'b0, rst = 1'b1;
  logic [3:0] sel = 4'h0;
  logic [17:0] lanes;
  logic cs_n, dc, wr_n;
  logic [3:0] mode, bits;
  logic mval, ser, split, cv, pv, xv, rgb;
  logic [7:0] cb, pb;
  logic [17:0] px;
  int n_fail = 0, cmp_count = 0, n_cmd = 0, n_par = 0, cyc = 0;
  himsel_top dut (.i_ref_clk(clk), .i_rst(rst), .i_iface_sel_bit3(sel[3]),
    .i_iface_sel_bit2(sel[2]), .i_iface_sel_bit1(sel[1]), .i_iface_sel_bit0(sel[0]),
    .i_host_data_lanes(lanes), .i_chip_select_n(cs_n), .i_data_cmd_select(dc),
    .i_write_n(wr_n), .o_mode(mode), .o_mode_valid(mval), .o_serial_mode(ser),
    .o_serial_split(split), .o_serial_word_bits(bits), .o_cmd_valid(cv), .o_cmd_byte(cb),
    .o_param_valid(pv), .o_param_byte(pb), .o_pixel_valid(xv), .o_pixel_word(px),
    .o_rgb_allowed(rgb));
  himsel_host host (.i_clk(clk), .o_lanes(lanes), .o_cs_n(cs_n), .o_dc(dc), .o_wr_n(wr_n));
  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cv === 1'b1) n_cmd <= n_cmd + 1;
    if (pv === 1'b1 && xv === 1'b1) n_par <= n_par + 1;
    if (cyc == 6000)
    begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
    cmp_count++;
  endtask
  function automatic logic [7:0] e_cmd(input logic [3:0] c, input logic [17:0] d);
    return (c inside {4'h8, 4'hA}) ? d[8:1] : (c inside {4'h9, 4'hB}) ? d[17:10] : d[7:0];
  endfunction
  function automatic logic [17:0] e_pix(input logic [3:0] c, input logic [17:0] d);
    case (c)
      4'h0: return {10'h000, d[7:0]};
      4'h1: return {2'h0, d[15:0]};
      4'h2: return {9'h000, d[8:0]};
      4'h8: return {2'h0, d[17:10], d[8:1]};
      4'h9: return {10'h000, d[17:10]};
      4'hB: return {9'h000, d[17:9]};
      default: return d;
    endcase
  endfunction
  task automatic t_modes();
    logic [3:0] m;
    logic par, sm;
    int b0, b1;
    for (int c = 0; c < 16; c++)
    begin
      @(negedge clk);
      sel = c[3:0];
      repeat (6) @(negedge clk);
      m = (c < 4) ? c[3:0] : (c == 5) ? 4'h4 : (c == 6) ? 4'h5 : (c >= 8 && c < 12) ?
          4'(c - 2) : (c == 13) ? 4'hA : (c == 14) ? 4'hB : 4'hC;
      sm = m inside {4'h4, 4'h5, 4'hA, 4'hB};
      par = (m != 4'hC) && !sm;
      chk(18'(mode), 18'(m));
      chk(18'(mval), 18'(m != 4'hC));
      chk(18'({ser, split, rgb}), 18'({sm, m > 4'h9 && sm, sm}));
      chk(18'(bits), (m inside {4'h4, 4'hA}) ? 18'h9 : sm ? 18'h8 : 18'h0);
      b0 = n_cmd;
      b1 = n_par;
      host.write(1'b0, 1'b0, 18'h2B4E1);
      host.write(1'b0, 1'b1, 18'h1C3A5);
      repeat (4) @(negedge clk);
      chk(18'(n_cmd - b0), 18'(par));
      chk(18'(n_par - b1), 18'(par));
      if (par)
      begin
        chk(18'(cb), 18'(e_cmd(c[3:0], 18'h2B4E1)));
        chk(18'(pb), 18'(e_cmd(c[3:0], 18'h1C3A5)));
        chk(px, e_pix(c[3:0], 18'h1C3A5));
      end
    end
  endtask
  task automatic t_cs();
    int b0;
    @(negedge clk);
    sel = 4'h0;
    repeat (6) @(negedge clk);
    b0 = n_cmd;
    host.write(1'b1, 1'b0, 18'h000A5);
    host.write(1'b0, 1'b0, 18'h0003C);
    host.write(1'b0, 1'b0, 18'h000C3);
    repeat (4) @(negedge clk);
    chk(18'(n_cmd - b0), 18'h2);
    chk(18'(cb), 18'h000C3);
  endtask
  task automatic test_done();
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_modes();
    t_cs();
    test_done();
  end
endmodule
bind himsel_top himsel_asserts u_chk (.i_ref_clk, .i_rst, .i_chip_select_n, .o_mode,
  .o_mode_valid, .o_serial_mode, .o_serial_split, .o_serial_word_bits, .o_cmd_valid,
  .o_param_valid, .o_pixel_valid, .o_rgb_allowed);
